//--- tdm_connection_memory_delay_test.sv
// Self-checking bench for the TDM connection memory block
`timescale 1ns/1ps
module tdm_connection_memory_delay_test;
	logic        core_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
	logic [15:0] s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, serial_input, serial_output;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, input_clock;
	logic [1:0]  s_axi_bresp, s_axi_rresp, input_rate_pins;
	logic        input_frame_pulse, output_frame_pulse;
	logic [3:0]  output_clocks;
	logic [7:0]  frame_no, f0, rx [32], rx_fr [32];
	int          fails, tests_run;
	// Stream 1 targets: channel, low word, frames back, expected key
	int          tn [7] = '{10, 11, 4, 1, 21, 22, 20};
	logic [15:0] tl [7] = '{16'h0002, 16'h4604, 16'h4604, 16'h400A,
		16'h082A, 16'h882C, 16'h0529};
	logic [2:0]  td [7] = '{3'h2, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h0};
	logic [7:0]  tk [7] = '{8'h01, 8'h01, 8'h01, 8'h05, 8'h11, 8'h47, 8'hA5};
	tdmcm_switch dut_u (.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(1'b1), .input_clock(input_clock),
		.input_frame_pulse(input_frame_pulse),
		.input_rate_pins(input_rate_pins), .serial_input(serial_input),
		.serial_output(serial_output), .output_clocks(output_clocks),
		.output_frame_pulse(output_frame_pulse));
	tdmcm_stream_model far_u (.core_clk(core_clk),
		.serial_output(serial_output), .input_clock(input_clock),
		.input_frame_pulse(input_frame_pulse), .serial_input(serial_input),
		.frame_no(frame_no), .rx(rx), .rx_fr(rx_fr));
	// ------------------------------------------------------------
	// Compare, bus tasks and verdict
	// ------------------------------------------------------------
	task automatic ck(input string nm, input logic [15:0] e,
		input logic [15:0] s);
		tests_run++;
		if (s !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		ck("bresp", 16'(tdmcm_pkg::RESP_OK), 16'(s_axi_bresp));
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata[15:0];
	endtask
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd(a, d);
		ck($sformatf("read %h", a), e, d);
	endtask
	// Low word of a stream and channel; high word sits 0x1000 above
	function automatic logic [15:0] cm(input int s, input int c);
		return 16'h1000 + 16'(4 * (s * 32 + c));
	endfunction
	task final_report;
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// Whole run is about 55k cycles
	initial
	begin
		#380000;
		fails++;
		final_report;
	end
	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_awaddr = 16'h0000;
		s_axi_araddr = 16'h0000;
		s_axi_wdata = 32'h0;
		input_rate_pins = 2'h3;
		fails = 0;
		tests_run = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rc(tdmcm_pkg::A_CTRL, tdmcm_pkg::CTRL_RST);
		rc(tdmcm_pkg::A_MODE, tdmcm_pkg::MODE_RST);
		rc(tdmcm_pkg::A_STAT, 16'h000C);
		rd(16'h000C, v);
		ck("rresp", 16'(tdmcm_pkg::RESP_ERR), 16'(s_axi_rresp));
		// Bulk fill with pattern 6, then wait for the start bit to clear
		wr(tdmcm_pkg::A_CTRL, 16'h0008);
		wr(tdmcm_pkg::A_MODE, 16'h000D);
		f0 = frame_no;
		do
			rd(tdmcm_pkg::A_MODE, v);
		while (v[0] === 1'b1);
		ck("fill frames", 16'h1, {15'h0, frame_no - f0 >= 8'h02});
		rc(cm(7, 9), 16'h0006);
		rc(cm(7, 9) + 16'h1000, 16'h0000);
		wr(tdmcm_pkg::A_CTRL, 16'h0010);
		wr(cm(9, 9), 16'hFFFF);
		rc(cm(9, 9), 16'hFFFF);
		wr(cm(9, 9) + 16'h1000, 16'h001F);
		rc(cm(9, 9) + 16'h1000, 16'h001F);
		// High words go in before any law enable
		wr(cm(1, 21) + 16'h1000, 16'h0003);
		wr(cm(1, 22) + 16'h1000, 16'h0003);
		for (int i = 0; i < 7; i++)
			wr(cm(1, tn[i]), tl[i]);
		f0 = frame_no;
		wait (frame_no == f0 + 8'h04);
		for (int i = 0; i < 7; i++)
			ck($sformatf("rx ch %0d", tn[i]), {8'h00, tk[i] ^ (tl[i][0]
				? 8'h00 : {rx_fr[tn[i]][2:0] - td[i], 5'h00})},
				{8'h00, rx[tn[i]]});
		// Fill stopped by clearing start before the walk gets far
		wr(cm(31, 31), 16'h0ABC);
		wr(tdmcm_pkg::A_CTRL, 16'h0018);
		wr(tdmcm_pkg::A_MODE, 16'h0003);
		wr(tdmcm_pkg::A_MODE, 16'h0000);
		rc(cm(31, 31), 16'h0ABC);
		wr(tdmcm_pkg::A_CTRL, 16'h0110);
		rc(tdmcm_pkg::A_STAT, 16'h000E);
		input_rate_pins <= 2'h1;
		rc(tdmcm_pkg::A_STAT, 16'h0016);
		final_report;
	end
endmodule
bind tdmcm_switch tdmcm_switch_chk chk_u (.core_clk(core_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.serial_output(serial_output), .output_clocks(output_clocks),
	.output_frame_pulse(output_frame_pulse));

//--- tdmcm_pkg.sv
// Constants for the TDM connection memory and throughput delay block
package tdmcm_pkg;
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int          NSTR      = 32;       // Serial streams
	localparam int          NCH       = 32;       // Channels per frame
	localparam int          NBANK     = 3;        // Frame banks of data
	localparam int          CMDEPTH   = 1024;     // Connection words
	localparam int          DMDEPTH   = 3072;     // Data bytes, 3 banks
	localparam logic [5:0]  VAR_SPAN  = 6'h07;    // Same-frame threshold
	localparam logic [1:0]  BP_FRAMES = 2'h3;     // Frame starts per fill
	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] A_CTRL    = 16'h0000; // Main control
	localparam logic [15:0] A_MODE    = 16'h0004; // Internal mode
	localparam logic [15:0] A_STAT    = 16'h0008; // Status
	localparam logic [3:0]  R_CML     = 4'h1;     // Low words region
	localparam logic [3:0]  R_CMH     = 4'h2;     // High words region
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int          CTRL_VAR  = 4;        // Chip variable enable
	localparam int          CTRL_BPE  = 3;        // Block program enable
	localparam int          CTRL_CKM  = 8;        // Clock mode bit
	localparam int          MODE_GO   = 0;        // Block program start
	localparam int          CML_SEL   = 0;        // Mode select
	localparam int          CML_SCL   = 1;        // Source channel lsb
	localparam int          CML_SSL   = 9;        // Source stream lsb
	localparam int          CML_MSGL  = 3;        // Message byte lsb
	localparam int          CML_VAR   = 14;       // Delay type
	localparam int          CML_LAW   = 15;       // Law enable
	localparam int          CMH_VOICE = 0;        // Voice flag
	localparam int          CMH_INL   = 1;        // Input law
	localparam int          CMH_OUTL  = 2;        // Output law
	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [15:0] CTRL_RST  = 16'h0000; // Control reset
	localparam logic [15:0] MODE_RST  = 16'h0000; // Mode reset
	localparam logic [7:0]  LAW_MASK  = 8'h55;    // Law swap pattern
	localparam logic [1:0]  RATE_4M   = 2'h3;     // Slow input clock
	localparam logic [1:0]  RATE_8_16 = 2'h0;     // Fast input clock
	localparam logic [1:0]  RESP_OK   = 2'h0;     // AXI OKAY
	localparam logic [1:0]  RESP_ERR  = 2'h2;     // AXI SLVERR
endpackage

//--- tdmcm_stream_model.sv
// Far-end TDM stream source and receiver of output stream 1
`timescale 1ns/1ps
module tdmcm_stream_model (
	input  wire logic        core_clk,
	input  wire logic [31:0] serial_output,
	output logic             input_clock,
	output logic             input_frame_pulse,
	output logic [31:0]      serial_input,
	output logic [7:0]       frame_no,
	output logic [7:0]       rx [32],
	output logic [7:0]       rx_fr [32]
);
	int         ph;    // Core cycles into the bit period
	logic [7:0] bitn;  // Bit index strobed last
	logic [7:0] nb;    // Next bit index
	logic [7:0] nf;    // Frame of the next bit
	logic [7:0] sh;    // Receive shifter
	logic [7:0] by;    // Byte sent on one stream
	assign nb = bitn + 8'h01;
	assign nf = frame_no + {7'h00, nb == 8'h00};
	initial
	begin
		ph = 0;
		input_clock = 1'b0;
		input_frame_pulse = 1'b0;
		serial_input = 32'h0;
		frame_no = 8'h00;
		bitn = 8'hFF;
		sh = 8'h00;
	end
	// Bit clock of 36 core cycles, above the 34-cycle scan floor.
	// Data change on the falling edge so the rising strobe sees it
	// settled; byte = frame count and channel, stream-tagged.
	always @(posedge core_clk)
	begin
		ph <= (ph == 35) ? 0 : ph + 1;
		if (ph == 17)
			input_clock <= 1'b1;
		if (ph == 35)
		begin
			input_clock <= 1'b0;
			sh <= {sh[6:0], serial_output[1]};
			if (nb[2:0] == 3'h7)
			begin
				rx[nb[7:3]] <= {sh[6:0], serial_output[1]};
				rx_fr[nb[7:3]] <= nf;
			end
			for (int s = 0; s < 32; s++)
			begin
				by = {nf[2:0], nb[7:3] ^ 5'(s)};
				serial_input[s] <= by[~nb[2:0]];
			end
			input_frame_pulse <= nb == 8'h00;
			bitn <= nb;
			frame_no <= nf;
		end
	end
endmodule

//--- tdmcm_switch.sv
// TDM switch core: connection memory, delay banks, block fill, AXI slave
// Functional notes
// - Variable delay sends channels as early as possible
// - Variable without chip enable: output not guaranteed
// - Variable delay follows output minus input channel
// - Constant delay is two frames plus n-m
// - Delay-type bit low forces constant delay
// - 16-bit low, 5-bit high word, zeros above
// - Law enable low: no conversion, high ignored
// - Mode select low: normal source channel switching
// - Mode select high: message byte output
// - Fill writes pattern, clears everything else
// - Block fill lasts at least two frames
// - Device clears start bit on completion
// - Clearing start or enable aborts fill
// - Divided mode divides the input clock
// - Multiplied mode uses internal locked clock
// - Rate pins and clock-mode bit pick mode
// - Inputs on input clock; outputs per mode
// - High word read returns zeros above bit 4
`timescale 1ns/1ps
module tdmcm_switch (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [15:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [15:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        input_clock,
	input  wire logic        input_frame_pulse,
	input  wire logic [1:0]  input_rate_pins,
	input  wire logic [31:0] serial_input,
	output logic [31:0]      serial_output,
	output logic [3:0]       output_clocks,
	output logic             output_frame_pulse
);
	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	// Bank arithmetic modulo three
	function automatic logic [1:0] bank_add(input logic [1:0] b,
		input logic [1:0] k);
		logic [2:0] s;
		s = {1'b0, b} + {1'b0, k};
		bank_add = (s >= 3'h3) ? 2'(s - 3'h3) : s[1:0];
	endfunction
	// Byte-lane merge into a 16-bit word
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] st);
		lane_merge = {st[1] ? d[15:8] : old[15:8],
			st[0] ? d[7:0] : old[7:0]};
	endfunction
	// Region decode, used by both read and write paths
	function automatic logic [1:0] region(input logic [15:0] a);
		if (a[15:12] == tdmcm_pkg::R_CML)
			region = 2'h1;
		else if (a[15:12] == tdmcm_pkg::R_CMH)
			region = 2'h2;
		else
			region = 2'h0;
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [15:0] cm_low  [0:tdmcm_pkg::CMDEPTH-1]; // Low words
	logic [4:0]  cm_high [0:tdmcm_pkg::CMDEPTH-1]; // High words
	logic [7:0]  dmem    [0:tdmcm_pkg::DMDEPTH-1]; // Banked input data
	logic [15:0] ctrl;                             // Main control
	logic [15:0] mode;                             // Internal mode
	logic [7:0]  in_sh   [0:31];                   // Input shifters
	logic [7:0]  hold    [0:31];                   // Captured bytes
	logic [7:0]  out_nx  [0:31];                   // Next output bytes
	logic [7:0]  out_sh  [0:31];                   // Output shifters

	// ----------------------------------------------------------------
	// Input timing
	// ----------------------------------------------------------------
	logic       clk_q;      // Previous input clock level
	logic       half_q;     // Divide-by-two for fast inputs
	logic [2:0] bit_cnt;    // Next bit index
	logic [4:0] ch_cnt;     // Current channel
	logic [1:0] bank;       // Frame bank being filled
	logic [2:0] dv_cnt;     // Divided clock counter
	wire        in_edge  = input_clock & ~clk_q;
	wire        rate4    = (input_rate_pins == tdmcm_pkg::RATE_4M);
	wire        bit_stb  = in_edge & (rate4 | half_q);
	wire        fstart   = bit_stb & input_frame_pulse;
	wire  [2:0] cur_bit  = fstart ? 3'h0 : bit_cnt;
	wire  [4:0] cur_ch   = fstart ? 5'h00 : ch_cnt;
	wire        chan_end = bit_stb & (cur_bit == 3'h7);
	wire        ckm      = ctrl[tdmcm_pkg::CTRL_CKM];

	// Bit, channel and frame-bank counters, relocked at frame start
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			clk_q   <= 1'b0;
			half_q  <= 1'b0;
			bit_cnt <= 3'h0;
			ch_cnt  <= 5'h00;
			bank    <= 2'h0;
			dv_cnt  <= 3'h0;
		end
		else
		begin
			clk_q  <= input_clock;
			// 8/16 rate: one bit per two input clocks
			half_q <= in_edge ? ~half_q : half_q;
			dv_cnt <= in_edge ? dv_cnt + 3'h1 : dv_cnt;
			if (bit_stb)
			begin
				bit_cnt <= cur_bit + 3'h1;
				ch_cnt  <= (cur_bit == 3'h7) ? cur_ch + 5'h01 : cur_ch;
			end
			if (fstart)
				bank <= bank_add(bank, 2'h1);
		end
	end

	// ----------------------------------------------------------------
	// Multiplied clock, locked to the input bit period and frame pulse
	// ----------------------------------------------------------------
	logic [7:0] per_cnt;   // Cycles since last bit strobe
	logic [7:0] per_meas;  // Measured bit period
	logic [7:0] mph;       // Internal phase counter
	logic [3:0] mcnt;      // Internal clock divider
	wire        mult_stb = (mph == per_meas);
	wire        out_stb  = ckm ? mult_stb : bit_stb;

	// Period tracking; phase restarts at frame start
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			per_cnt  <= 8'h00;
			per_meas <= 8'hFF;
			mph      <= 8'h00;
			mcnt     <= 4'h0;
		end
		else
		begin
			per_cnt  <= bit_stb ? 8'h00 : per_cnt + {7'h00, ~&per_cnt};
			per_meas <= bit_stb ? per_cnt : per_meas;
			mph      <= (fstart | mult_stb) ? 8'h00 : mph + 8'h01;
			mcnt     <= fstart ? 4'h0 : mcnt + 4'h1;
		end
	end

	// Output clocks: direct division, or internal clock taps
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			output_clocks      <= 4'h0;
			output_frame_pulse <= 1'b0;
		end
		else
		begin
			// Divided taps never run faster than the input clock
			output_clocks <= ckm ? mcnt :
				{dv_cnt[2], dv_cnt[1], dv_cnt[0], clk_q};
			output_frame_pulse <= fstart;
		end
	end

	// ----------------------------------------------------------------
	// Per-stream serial shifters
	// ----------------------------------------------------------------
	genvar gs;
	generate
		for (gs = 0; gs < tdmcm_pkg::NSTR; gs++)
		begin : g_str
			// Inputs always sampled on input clock strobes
			always_ff @(posedge core_clk)
			begin
				if (rst)
				begin
					in_sh[gs]         <= 8'h00;
					hold[gs]          <= 8'h00;
					out_sh[gs]        <= 8'h00;
					serial_output[gs] <= 1'b0;
				end
				else
				begin
					if (bit_stb)
						in_sh[gs] <= {in_sh[gs][6:0], serial_input[gs]};
					if (chan_end)
						hold[gs] <= {in_sh[gs][6:0], serial_input[gs]};
					// Load at channel end, then shift MSB first
					if (chan_end)
						out_sh[gs] <= out_nx[gs];
					else if (out_stb)
						out_sh[gs] <= {out_sh[gs][6:0], 1'b0};
					serial_output[gs] <= chan_end ? out_nx[gs][7]
						: (out_stb ? out_sh[gs][6] : out_sh[gs][7]);
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Channel scan: store captured bytes, compute bytes two ahead
	// ----------------------------------------------------------------
	logic       scan_on;   // Scan in progress
	logic [4:0] scan_s;    // Stream being scanned
	logic [4:0] hold_ch;   // Channel of captured bytes
	logic [1:0] hold_bk;   // Bank of captured bytes
	wire  [4:0] tgt_ch   = hold_ch + 5'h02;
	wire  [1:0] tgt_bk   = (hold_ch >= 5'h1E) ?
		bank_add(hold_bk, 2'h1) : hold_bk;
	wire  [9:0] cm_idx   = {scan_s, tgt_ch};
	wire [15:0] cwl      = cm_low[cm_idx];
	wire  [4:0] cwh      = cm_high[cm_idx];
	wire  [4:0] src_ch   = cwl[tdmcm_pkg::CML_SCL +: 5];
	wire  [4:0] src_st   = cwl[tdmcm_pkg::CML_SSL +: 5];
	wire  [5:0] ch_diff  = {1'b0, tgt_ch} - {1'b0, src_ch};
	wire        diff_pos = ~ch_diff[5] & (ch_diff != 6'h00);
	// Variable only when both the channel and chip enable ask for it
	wire        var_eff  = cwl[tdmcm_pkg::CML_VAR]
		& ctrl[tdmcm_pkg::CTRL_VAR];
	// Constant two frames back; variable same frame when far enough ahead, else one back
	wire  [1:0] src_bk   = !var_eff ? bank_add(tgt_bk, 2'h1)
		: (diff_pos && ch_diff > tdmcm_pkg::VAR_SPAN) ? tgt_bk
		: bank_add(tgt_bk, 2'h2);
	wire [11:0] src_addr = {src_bk, src_st, src_ch[4:0]};
	wire  [7:0] sw_byte  = cwl[tdmcm_pkg::CML_SEL] ?
		cwl[tdmcm_pkg::CML_MSGL +: 8] : dmem[src_addr];
	wire        law_swap = cwh[tdmcm_pkg::CMH_VOICE]
		& (cwh[tdmcm_pkg::CMH_INL] ^ cwh[tdmcm_pkg::CMH_OUTL]);
	// High word has no effect unless the law enable is set
	wire  [7:0] fin_byte = (cwl[tdmcm_pkg::CML_LAW] & law_swap) ?
		sw_byte ^ tdmcm_pkg::LAW_MASK : sw_byte;

	// Scan walks all streams once per channel, one per cycle
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			scan_on <= 1'b0;
			scan_s  <= 5'h00;
			hold_ch <= 5'h00;
			hold_bk <= 2'h0;
		end
		else if (chan_end)
		begin
			scan_on <= 1'b1;
			scan_s  <= 5'h00;
			hold_ch <= cur_ch;
			hold_bk <= fstart ? bank_add(bank, 2'h1) : bank;
		end
		else if (scan_on)
		begin
			scan_on <= (scan_s != 5'h1F);
			scan_s  <= scan_s + 5'h01;
		end
	end

	// Data memory write and output byte update
	always_ff @(posedge core_clk)
	begin
		if (scan_on)
		begin
			dmem[{hold_bk, scan_s, hold_ch}] <= hold[scan_s];
			out_nx[scan_s] <= fin_byte;
		end
	end

	// ----------------------------------------------------------------
	// Block programming
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {TDMCM_BP_IDLE, TDMCM_BP_WALK,
		TDMCM_BP_WAIT} tdmcm_bp_t;
	tdmcm_bp_t  bp_st;     // Fill state
	logic [9:0] bp_addr;   // Fill address
	logic [1:0] bp_frm;    // Frame starts seen
	logic       bp_done;   // Completion pulse
	wire        bp_req   = ctrl[tdmcm_pkg::CTRL_BPE]
		& mode[tdmcm_pkg::MODE_GO];
	wire        bp_busy  = (bp_st != TDMCM_BP_IDLE);
	wire        bp_wr    = (bp_st == TDMCM_BP_WALK);

	// Fill walk; spans two whole frames; abort on any clear
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			bp_st   <= TDMCM_BP_IDLE;
			bp_addr <= 10'h000;
			bp_frm  <= 2'h0;
			bp_done <= 1'b0;
		end
		else
		begin
			bp_done <= 1'b0;
			if (fstart && bp_busy && bp_frm != tdmcm_pkg::BP_FRAMES)
				bp_frm <= bp_frm + 2'h1;
			unique case (bp_st)
				TDMCM_BP_IDLE:
				begin
					bp_addr <= 10'h000;
					bp_frm  <= 2'h0;
					if (bp_req)
						bp_st <= TDMCM_BP_WALK;
				end
				TDMCM_BP_WALK:
				begin
					bp_addr <= bp_addr + 10'h001;
					if (!bp_req)
						bp_st <= TDMCM_BP_IDLE;
					else if (&bp_addr)
						bp_st <= TDMCM_BP_WAIT;
				end
				TDMCM_BP_WAIT:
				begin
					if (!bp_req)
						bp_st <= TDMCM_BP_IDLE;
					else if (bp_frm == tdmcm_pkg::BP_FRAMES)
					begin
						bp_st   <= TDMCM_BP_IDLE;
						bp_done <= 1'b1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic [15:0] aw_a;     // Held write address
	logic [31:0] w_d;      // Held write data
	logic [3:0]  w_s;      // Held write strobes
	wire         wr_go  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire  [1:0]  wr_rg  = region(aw_a);
	wire  [9:0]  wr_ix  = aw_a[11:2];
	wire  [1:0]  rd_rg  = region(s_axi_araddr);
	wire  [9:0]  rd_ix  = s_axi_araddr[11:2];
	wire         wr_ok  = (wr_rg != 2'h0) || aw_a == tdmcm_pkg::A_CTRL
		|| aw_a == tdmcm_pkg::A_MODE || aw_a == tdmcm_pkg::A_STAT;
	wire         rd_ok  = (rd_rg != 2'h0)
		|| s_axi_araddr == tdmcm_pkg::A_CTRL
		|| s_axi_araddr == tdmcm_pkg::A_MODE
		|| s_axi_araddr == tdmcm_pkg::A_STAT;
	wire  [15:0] stat   = {11'h000, input_rate_pins != tdmcm_pkg::RATE_4M
		&& input_rate_pins != tdmcm_pkg::RATE_8_16,
		input_rate_pins, ckm, bp_busy};
	// High word reads carry zeros above its five bits
	wire  [15:0] rd_w   = (rd_rg == 2'h1) ? cm_low[rd_ix]
		: (rd_rg == 2'h2) ? {11'h000, cm_high[rd_ix]}
		: (s_axi_araddr == tdmcm_pkg::A_CTRL) ? ctrl
		: (s_axi_araddr == tdmcm_pkg::A_MODE) ? mode
		: (s_axi_araddr == tdmcm_pkg::A_STAT) ? stat : 16'h0000;

	// Handshakes: one write and one read in flight
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tdmcm_pkg::RESP_OK;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= tdmcm_pkg::RESP_OK;
			aw_a          <= 16'h0000;
			w_d           <= 32'h00000000;
			w_s           <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_a          <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_d          <= s_axi_wdata;
				w_s          <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? tdmcm_pkg::RESP_OK
					: tdmcm_pkg::RESP_ERR;
			end
			else if (s_axi_bvalid & s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= {16'h0000, rd_w};
				s_axi_rresp   <= rd_ok ? tdmcm_pkg::RESP_OK
					: tdmcm_pkg::RESP_ERR;
			end
			else if (s_axi_rvalid & s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Control registers; completion clears only the start bit
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl <= tdmcm_pkg::CTRL_RST;
			mode <= tdmcm_pkg::MODE_RST;
		end
		else
		begin
			if (wr_go && aw_a == tdmcm_pkg::A_CTRL)
				ctrl <= lane_merge(ctrl, w_d, w_s);
			if (wr_go && aw_a == tdmcm_pkg::A_MODE)
				mode <= lane_merge(mode, w_d, w_s);
			else if (bp_done)
				mode[tdmcm_pkg::MODE_GO] <= 1'b0;
		end
	end

	// Connection memory port: fill owns it while walking
	always_ff @(posedge core_clk)
	begin
		if (bp_wr)
		begin
			cm_low[bp_addr]  <= {13'h0000, mode[3:1]};
			cm_high[bp_addr] <= 5'h00;
		end
		else if (wr_go && wr_rg == 2'h1 && !bp_busy)
			cm_low[wr_ix] <= lane_merge(cm_low[wr_ix], w_d, w_s);
		else if (wr_go && wr_rg == 2'h2 && !bp_busy && w_s[0])
			cm_high[wr_ix] <= w_d[4:0];
	end
endmodule

//--- tdmcm_switch_chk.sv
// Port-level protocol and readback checks for the TDM switch
`timescale 1ns/1ps
module tdmcm_switch_chk (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] serial_output,
	input wire logic [3:0]  output_clocks,
	input wire logic        output_frame_pulse
);
	// ------------------------------------------------------------
	// Helper logic: what the read in flight addressed
	// ------------------------------------------------------------
	logic rd_high;  // Read targets the high connection words
	logic rd_bad;   // Read targets the unmapped word 0x000C
	always_ff @(posedge core_clk)
	begin
		if (s_axi_arvalid && s_axi_arready)
		begin
			rd_high <= s_axi_araddr[15:12] == tdmcm_pkg::R_CMH;
			rd_bad  <= s_axi_araddr == 16'h000C;
		end
	end
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer missing");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer missing");
	a_ready_low: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("ready early");
	a_upper_zero: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
	a_high_zero: assert property (s_axi_rvalid && rd_high
		|-> s_axi_rdata[15:5] == 11'h000) else $error("high word bits set");
	a_bad_resp: assert property (s_axi_rvalid && rd_bad
		|-> s_axi_rresp == tdmcm_pkg::RESP_ERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_pulse_once: assert property ($rose(output_frame_pulse)
		|=> !output_frame_pulse) else $error("frame pulse too long");
	a_reset_quiet: assert property (@(posedge core_clk) disable iff (1'b0)
		rst |=> output_clocks == 4'h0 && serial_output == 32'h0)
		else $error("outputs live in reset");
	// Main scenarios reached
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_high: cover property (s_axi_rvalid && rd_high);
	c_frame: cover property (output_frame_pulse);
endmodule
